// [common/rx_modem_config_params.svh]
`ifndef RX_MODEM_CONFIG_PARAMS_SVH
`define RX_MODEM_CONFIG_PARAMS_SVH

// Register indices; the APB byte address of each register is four times its index.
`define IDX_CHAN_FILTER 8'h1c
`define IDX_OSR_LO 8'h20
`define IDX_OFS2 8'h21
`define IDX_OFS1 8'h22
`define IDX_OFS0 8'h23
`define IDX_GAIN_HI 8'h24
`define IDX_GAIN_LO 8'h25
`define IDX_RATE_HI 8'h6e
`define IDX_RATE_LO 8'h6f
`define IDX_MOD_CTRL1 8'h70
`define IDX_MOD_CTRL2 8'h71
`define IDX_STATUS 8'h7f

// Channel filter register fields.
`define CHF_SKIP_BIT 7
`define CHF_DEC_MSB 6
`define CHF_DEC_LSB 4
`define CHF_SET_MSB 3
`define CHF_SET_LSB 0

// Shared register 0x21: oversampling ratio top bits and offset top bits.
`define OFS2_OSR_MSB 7
`define OFS2_OSR_LSB 5
`define OFS2_NCO_MSB 3
`define OFS2_NCO_LSB 0
`define OFS2_WR_MASK 8'hef

// Gain high register keeps three live bits.
`define GAIN_HI_MSB 2
`define GAIN_HI_WR_MASK 8'h07

// Modulation control fields.
`define MOD1_RATE_SCALE_BIT 5
`define MOD1_MANCH_BIT 1
`define MOD2_TYPE_MSB 1
`define MOD2_TYPE_LSB 0
`define MODTYP_ON_OFF 2'h1

// Reset value of every configuration register.
`define CFG_RESET_BYTE 8'h00

`endif

// [common/rx_modem_config_pkg.sv]
`default_nettype none
package rx_modem_config_pkg;

	// Raw register image as software wrote it.
	typedef struct packed {
		logic [7:0] chan_filter;
		logic [7:0] osr_lo;
		logic [7:0] ofs2;
		logic [7:0] ofs1;
		logic [7:0] ofs0;
		logic [7:0] gain_hi;
		logic [7:0] gain_lo;
		logic [7:0] rate_hi;
		logic [7:0] rate_lo;
		logic [7:0] mod_ctrl1;
		logic [7:0] mod_ctrl2;
	} modem_regs_t;

	// Decoded settings handed to the demodulator.
	typedef struct packed {
		logic on_off_keying;
		logic manchester_en;
		logic rate_scale;
		logic [15:0] data_rate;
		logic [16:0] symbol_rate;
		logic third_divider_skip;
		logic [2:0] dec_exp;
		logic [3:0] filter_set;
		logic [10:0] osr;
		logic [19:0] nco_offset;
		logic [10:0] loop_gain;
	} modem_cfg_t;

	// Whole state of the configuration block.
	typedef struct packed {
		modem_regs_t regs;
		modem_cfg_t cfg;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cfg_state_t;

endpackage : rx_modem_config_pkg
`default_nettype wire

// [rtl/rx_cfg_unpack.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rx_modem_config_params.svh"

module rx_cfg_unpack (
	input wire rx_modem_config_pkg::modem_regs_t regs,
	output rx_modem_config_pkg::modem_cfg_t cfg
);

	// Field extraction is pure wiring; the caller registers the result.
	always_comb begin
		cfg.on_off_keying = (regs.mod_ctrl2[`MOD2_TYPE_MSB:`MOD2_TYPE_LSB] == `MODTYP_ON_OFF);
		cfg.manchester_en = regs.mod_ctrl1[`MOD1_MANCH_BIT];
		cfg.rate_scale = regs.mod_ctrl1[`MOD1_RATE_SCALE_BIT];
		cfg.data_rate = {regs.rate_hi, regs.rate_lo};
		// Manchester counts as one or zero, so it doubles or keeps the rate.
		cfg.symbol_rate = cfg.manchester_en ? {cfg.data_rate, 1'b0} : {1'b0, cfg.data_rate};
		cfg.third_divider_skip = regs.chan_filter[`CHF_SKIP_BIT];
		cfg.dec_exp = regs.chan_filter[`CHF_DEC_MSB:`CHF_DEC_LSB];
		cfg.filter_set = regs.chan_filter[`CHF_SET_MSB:`CHF_SET_LSB];
		cfg.osr = {regs.ofs2[`OFS2_OSR_MSB:`OFS2_OSR_LSB], regs.osr_lo};
		cfg.nco_offset = {regs.ofs2[`OFS2_NCO_MSB:`OFS2_NCO_LSB], regs.ofs1, regs.ofs0};
		cfg.loop_gain = {regs.gain_hi[`GAIN_HI_MSB:0], regs.gain_lo};
	end

endmodule : rx_cfg_unpack
`default_nettype wire

// [rtl/rx_modem_config.sv]
// Summary of operation
// - Writing the on-off-keying code to the modulation type field selects on-off-keying operation.
// - The sixteen-bit data rate is the upper byte at 0x6E joined with the lower byte at 0x6F.
// - The Manchester enable bit turns on Manchester coding and doubles the effective symbol rate.
// - The channel filter register holds the divider skip at bit 7, exponent at 6:4, set at 3:0.
// - The eleven-bit oversampling ratio spans 0x20 and the top bits of 0x21 beside the offset.
`timescale 1ns/1ps
`default_nettype none
`include "rx_modem_config_params.svh"

module rx_modem_config #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output rx_modem_config_pkg::modem_cfg_t modem_cfg
);

	////////////////////////////////////////////////////////////////////////////////
	// State and decode.

	// Register map, one byte per word in bits 7:0 except the wider 0x7F status word, byte address four times the index:
	//   0x1C channel filter: bit 7 divider skip, bits 6:4 exponent, bits 3:0 filter set.
	//   0x20 oversampling ratio bits 7:0.
	//   0x21 ratio bits 10:8 in 7:5, bit 4 always zero, offset bits 19:16 in 3:0.
	//   0x22 and 0x23 clock recovery offset bits 15:8 and 7:0.
	//   0x24 loop gain bits 10:8 in 2:0; the upper bits read as zero.
	//   0x25 loop gain bits 7:0.
	//   0x6E and 0x6F data rate bits 15:8 and 7:0.
	//   0x70 rate scaling at bit 5, Manchester enable at bit 1; other bits are stored.
	//   0x71 modulation type at bits 1:0; other bits are stored.
	//   0x7F read-only status taken from the settings the demodulator is using.
	// Multi-byte fields have no shadow copy: the demodulator sees each byte as it lands,
	// so software must finish a field before it relies on the combined value.
	// Unmapped indices, misaligned addresses and stray upper address bits get an error
	// response and no write. Writes with the low strobe clear are accepted and dropped,
	// since every writable register lives entirely in byte lane zero.

	rx_modem_config_pkg::cfg_state_t s_q;
	rx_modem_config_pkg::cfg_state_t s_d;
	rx_modem_config_pkg::modem_cfg_t cfg_now;
	logic [7:0] idx;
	logic addr_ok;
	logic mapped;
	logic setup_phase;
	logic access_done;
	logic [31:0] rd_word;

	// Register index comes from the word address; stray low or high bits never alias.
	assign idx = paddr[9:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && s_q.pready;

	// The unpacker turns the stored bytes into demodulator settings.
	rx_cfg_unpack u_unpack (
		.regs(s_q.regs),
		.cfg(cfg_now)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer and address map.

	// Narrow registers sit in the low byte; everything above reads as zero.
	always_comb begin
		mapped = addr_ok;
		rd_word = 32'h0000_0000;
		case (idx)
			`IDX_CHAN_FILTER: begin
				rd_word[7:0] = s_q.regs.chan_filter;
			end
			`IDX_OSR_LO: begin
				rd_word[7:0] = s_q.regs.osr_lo;
			end
			`IDX_OFS2: begin
				rd_word[7:0] = s_q.regs.ofs2;
			end
			`IDX_OFS1: begin
				rd_word[7:0] = s_q.regs.ofs1;
			end
			`IDX_OFS0: begin
				rd_word[7:0] = s_q.regs.ofs0;
			end
			`IDX_GAIN_HI: begin
				rd_word[7:0] = s_q.regs.gain_hi;
			end
			`IDX_GAIN_LO: begin
				rd_word[7:0] = s_q.regs.gain_lo;
			end
			`IDX_RATE_HI: begin
				rd_word[7:0] = s_q.regs.rate_hi;
			end
			`IDX_RATE_LO: begin
				rd_word[7:0] = s_q.regs.rate_lo;
			end
			`IDX_MOD_CTRL1: begin
				rd_word[7:0] = s_q.regs.mod_ctrl1;
			end
			`IDX_MOD_CTRL2: begin
				rd_word[7:0] = s_q.regs.mod_ctrl2;
			end
			`IDX_STATUS: begin
				// Live view of what the demodulator is actually using.
				rd_word = {7'h00, s_q.cfg.symbol_rate, 5'h00, s_q.cfg.third_divider_skip,
					s_q.cfg.manchester_en, s_q.cfg.on_off_keying};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// The slave answers in the first access cycle: the setup cycle arms pready.
	// Writes land only in the completing access cycle, so a stalled master
	// never produces a half-written field.
	// Seen from the master: setup at edge N, pready with the answer at edge N+1,
	// so this block adds no wait states and never stalls the bus.
	// A read returns the register as it stood at the setup edge.
	always_comb begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		// Settings follow the register image one cycle later, as one coherent word.
		s_d.cfg = cfg_now;
		if (setup_phase) begin
			s_d.pready = 1'b1;
			s_d.pslverr = !mapped;
			s_d.prdata = (!pwrite && mapped) ? rd_word : 32'h0000_0000;
		end
		if (access_done && pwrite && !s_q.pslverr && pstrb[0]) begin
			case (idx)
				`IDX_CHAN_FILTER: begin
					s_d.regs.chan_filter = pwdata[7:0];
				end
				`IDX_OSR_LO: begin
					s_d.regs.osr_lo = pwdata[7:0];
				end
				`IDX_OFS2: begin
					// Bit 4 is unused and kept at zero.
					s_d.regs.ofs2 = pwdata[7:0] & `OFS2_WR_MASK;
				end
				`IDX_OFS1: begin
					s_d.regs.ofs1 = pwdata[7:0];
				end
				`IDX_OFS0: begin
					s_d.regs.ofs0 = pwdata[7:0];
				end
				`IDX_GAIN_HI: begin
					s_d.regs.gain_hi = pwdata[7:0] & `GAIN_HI_WR_MASK;
				end
				`IDX_GAIN_LO: begin
					s_d.regs.gain_lo = pwdata[7:0];
				end
				`IDX_RATE_HI: begin
					s_d.regs.rate_hi = pwdata[7:0];
				end
				`IDX_RATE_LO: begin
					s_d.regs.rate_lo = pwdata[7:0];
				end
				`IDX_MOD_CTRL1: begin
					s_d.regs.mod_ctrl1 = pwdata[7:0];
				end
				`IDX_MOD_CTRL2: begin
					s_d.regs.mod_ctrl2 = pwdata[7:0];
				end
				default: begin
					// Status is read-only; writes to it are dropped quietly.
					s_d.regs = s_q.regs;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Every field resets to a constant; no port value is captured under reset.
	// The settings clear with the image, so the demodulator never sees a half-reset mix.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.regs <= {11{`CFG_RESET_BYTE}};
			s_q.cfg <= '0;
			s_q.pready <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.prdata <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register.

	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign prdata = s_q.prdata;
	assign modem_cfg = s_q.cfg;

endmodule : rx_modem_config
`default_nettype wire

// [verif/rx_modem_config_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_modem_config_asserts #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire rx_modem_config_pkg::modem_cfg_t modem_cfg
);
	logic wr_ok;
	logic [7:0] wd_q;
	// A write lands only at a clean completion edge with the low byte enabled.
	assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
	// Keep the byte of the last landed write, since the bus moves on before the fields settle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) wd_q <= 8'h00;
		else if (wr_ok) wd_q <= pwdata[7:0];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("bad error reply");
	a_keying_mode: assert property (wr_ok && paddr == ADDR_W'(12'h1c4)
		|=> ##1 modem_cfg.on_off_keying == (wd_q[1:0] == 2'h1)) else $error("mode wrong");
	a_filter_fields: assert property (wr_ok && paddr == ADDR_W'(12'h070) |=> ##1
		{modem_cfg.third_divider_skip, modem_cfg.dec_exp, modem_cfg.filter_set} == wd_q)
		else $error("filter fields wrong");
	a_rate_high: assert property (wr_ok && paddr == ADDR_W'(12'h1b8)
		|=> ##1 modem_cfg.data_rate[15:8] == wd_q) else $error("rate wrong");
	a_manch_bit: assert property (wr_ok && paddr == ADDR_W'(12'h1c0)
		|=> ##1 modem_cfg.manchester_en == wd_q[1]) else $error("manchester wrong");
	a_osr_low: assert property (wr_ok && paddr == ADDR_W'(12'h080)
		|=> ##1 modem_cfg.osr[7:0] == wd_q) else $error("ratio wrong");
	a_sym_rate: assert property (modem_cfg.symbol_rate ==
		({1'b0, modem_cfg.data_rate} << modem_cfg.manchester_en)) else $error("symbol rate");
endmodule : rx_modem_config_asserts
////////////////////////////////////////
bind rx_modem_config rx_modem_config_asserts #(.ADDR_W(ADDR_W)) chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.modem_cfg(modem_cfg));
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	rx_modem_config_pkg::modem_cfg_t modem_cfg;
	int num_errors, cmp_count, cyc;
	// Reserved bits of the shared offset and gain registers read back as zero.
	// Then software settings: frequency-keying filters, and 9.6 kbps on-off keying
	// in a 335.5 kHz filter with Manchester off (ratio 0x271, offset 0x0346E, gain 0x06B).
	row_t rows [19] = '{'{8'h1c, 8'hb5, 8'hb5}, '{8'h20, 8'ha7, 8'ha7}, '{8'h21, 8'hff, 8'hef},
		'{8'h22, 8'h5a, 8'h5a}, '{8'h23, 8'hc3, 8'hc3}, '{8'h24, 8'hff, 8'h07},
		'{8'h25, 8'h3c, 8'h3c}, '{8'h6e, 8'h12, 8'h12}, '{8'h6f, 8'h34, 8'h34},
		'{8'h1c, 8'h52, 8'h52},
		'{8'h1c, 8'h11, 8'h11},
		'{8'h1c, 8'h98, 8'h98},
		'{8'h70, 8'h20, 8'h20},
		'{8'h20, 8'h71, 8'h71},
		'{8'h21, 8'h40, 8'h40},
		'{8'h22, 8'h34, 8'h34},
		'{8'h23, 8'h6e, 8'h6e},
		'{8'h24, 8'h00, 8'h00},
		'{8'h25, 8'h6b, 8'h6b}};
	rx_modem_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .modem_cfg(modem_cfg));
	////////////////////////////////////////
	// Free-running bus clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic summarize();
		$display("mismatches %0d in %0d checks", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask : check
	// One APB transfer; the wait for ready is open-ended and only the timeout cuts it.
	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] lo);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, lo};
		pwdata <= {24'h00_0000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Hang guard sized well above the whole sequence.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			summarize();
		end
	end
	////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h1c, 8'h00, 4'h1, 2'b00);
		check({rd, modem_cfg}, '0);
		foreach (rows[k]) begin
			apb(1, rows[k].idx, rows[k].wd, 4'h1, 2'b00);
			apb(0, rows[k].idx, 8'h00, 4'h1, 2'b00);
			check(rd, rows[k].rd);
		end
		check({modem_cfg.third_divider_skip, modem_cfg.dec_exp, modem_cfg.filter_set,
			modem_cfg.osr, modem_cfg.nco_offset, modem_cfg.loop_gain, modem_cfg.data_rate},
			{8'h98, 11'h271, 20'h0_346e, 11'h06b, 16'h1234});
		apb(1, 8'h70, 8'h22, 4'h1, 2'b00);
		apb(0, 8'h7f, 8'h00, 4'h1, 2'b00);
		check(rd, 32'h0024_6806);
		check({modem_cfg.rate_scale, modem_cfg.manchester_en}, 2'b11);
		for (int m = 0; m < 4; m++) begin
			apb(1, 8'h71, 8'(m), 4'h1, 2'b00);
			@(posedge pclk);
			#1 check(modem_cfg.on_off_keying, m == 1);
		end
		// Refused and ignored writes must leave the filter byte alone.
		apb(1, 8'h30, 8'hff, 4'h1, 2'b00);
		check(err, 1'b1);
		apb(1, 8'h1c, 8'h00, 4'h1, 2'b01);
		check(err, 1'b1);
		apb(1, 8'h1c, 8'h00, 4'h0, 2'b00);
		apb(1, 8'h7f, 8'hff, 4'h1, 2'b00);
		apb(0, 8'h1c, 8'h00, 4'h1, 2'b00);
		check({err, rd}, 33'h0_0000_0098);
		apb(0, 8'h30, 8'h00, 4'h1, 2'b00);
		check({err, rd}, 33'h1_0000_0000);
		@(posedge pclk);
		presetn <= 1'b0;
		#1 check(modem_cfg, '0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h1c, 8'h00, 4'h1, 2'b00);
		check(rd, 32'h0000_0000);
		summarize();
	end
endmodule : testbench
`default_nettype wire
